//--- pkg/level_irq_pkg.sv
// Types shared by the level interrupt unit.
// Assumes level_irq_regs.svh sits beside it on the include path.
`include "level_irq_regs.svh"
package level_irq_pkg;
	typedef logic [1:0] level_t;
	typedef logic [`WORD_W-1:0] word_t;
	typedef logic [`DEV_ADDR_W-1:0] dev_addr_t;
	typedef enum logic [4:0] {
		CH_IDLE = 5'h01,
		CH_ACK = 5'h02,
		CH_DPC = 5'h04,
		CH_CS = 5'h08,
		CH_DONE = 5'h10
	} chan_state_t;
	typedef enum logic [1:0] {
		XFER_DPC_BYTE = 2'h0,
		XFER_DPC_WORD = 2'h1,
		XFER_CS = 2'h2
	} xfer_t;
endpackage

//--- pkg/level_irq_regs.svh
// Sizes and counts, reset values and vector constants for the level interrupt unit.
// Assumes inclusion by the package, the main design file and the register bank file.
`ifndef LEVEL_IRQ_REGS_SVH
`define LEVEL_IRQ_REGS_SVH
`define LVL_COUNT 4
`define GPR_COUNT 8
`define WORD_W 16
`define DEV_ADDR_W 8
`define DEV_COUNT 256
`define LSR_W 5
`define LSR_RESET 5'h00
`define IP_RESET 16'h0000
`define MASK_RESET 4'h0
`define PSW_RESET 16'h0000
`define CS_MAX_BYTES 17'h0ffff
`define VEC_BASE 16'h0100
`define VEC_SHIFT 2
`endif

//--- sim/io_device_model.sv
// Device controller model: one interrupt source and one transfer responder.
// Assumes the unit synchronises every pin driven here.
module io_device_model (
	// Clock, reset and bench control
	input wire logic clk,
	input wire logic resetn,
	input wire logic irqGo,
	input wire logic [7:0] irqDev, readyDelay,
	input wire logic [15:0] devData,
	// Channel
	input wire logic chanIrqAck, chanStrobe,
	input wire logic [1:0] chanKind,
	output logic chanIrqReq, chanReady,
	output logic [7:0] chanIrqAddr,
	output logic [15:0] chanDataIn
);
	logic [7:0] waitCnt;
	logic csRun, strobeSeen;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			chanIrqReq <= 1'b0;
			chanIrqAddr <= 8'h00;
			chanReady <= 1'b0;
			chanDataIn <= 16'h0000;
			waitCnt <= 8'h00;
			csRun <= 1'b0;
			strobeSeen <= 1'b0;
		end else begin
			strobeSeen <= chanStrobe;
			// Request held until answered; address then released
			if (irqGo || (strobeSeen && !chanStrobe && csRun)) begin
				chanIrqReq <= 1'b1;
				chanIrqAddr <= irqDev;
			end else if (chanIrqAck && chanIrqReq) begin
				chanIrqReq <= 1'b0;
				chanIrqAddr <= ~chanIrqAddr;
			end
			if (chanStrobe && !chanReady) begin
				csRun <= chanKind == 2'h2;
				waitCnt <= waitCnt + 8'h01;
				if (waitCnt >= readyDelay) begin
					chanReady <= 1'b1;
					chanDataIn <= devData;
				end
			end else if (!chanStrobe) begin
				chanReady <= 1'b0;
				waitCnt <= 8'h00;
				chanDataIn <= ~chanDataIn; // Released: toggles so a stale word never passes
			end
		end
	end
endmodule

//--- sim/level_irq_unit_props.sv
// Checker for the level interrupt unit, on its top ports only.
// Assumes one clock domain; bound to the unit below.
module level_irq_unit_props (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Control and status
	input wire logic globalEnable, levelMaskWr, pswWr, classRaise, classReset, classActive,
	input wire logic [3:0] levelMaskIn, levelMask,
	input wire logic [15:0] pswIn, processorStateWord, vectorAddr,
	input wire logic [1:0] activeLevel, startKind, chanKind,
	// Channel side
	input wire logic chanIrqReq, chanIrqAck, vectorValid, startIo, startBusy, chanStrobe,
	input wire logic [7:0] chanIrqAddr, startDev, chanAddr
);
	//------
	// Properties
	//------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_reset; !$past(resetn) |-> activeLevel == 2'h3 && levelMask == 4'h0; endproperty
	a_reset: assert property (p_reset) else $error("state after reset wrong");
	property p_vpulse; vectorValid |=> !vectorValid; endproperty
	a_vpulse: assert property (p_vpulse) else $error("vector pulse too long");
	property p_vaddr; vectorValid |-> vectorAddr == 16'h0100 + {6'h00, chanIrqAddr, 2'h0}; endproperty
	a_vaddr: assert property (p_vaddr) else $error("vector address wrong");
	property p_vack; vectorValid |-> chanIrqAck; endproperty
	a_vack: assert property (p_vack) else $error("vector without acknowledge");
	property p_ackhold; chanIrqAck && chanIrqReq |=> chanIrqAck; endproperty
	a_ackhold: assert property (p_ackhold) else $error("acknowledge dropped early");
	property p_gate; vectorValid |-> $past(globalEnable); endproperty
	a_gate: assert property (p_gate) else $error("accept while disabled");
	property p_lvlmask; vectorValid |-> ($past(levelMask) & (4'h1 << activeLevel)) != 4'h0; endproperty
	a_lvlmask: assert property (p_lvlmask) else $error("accept on masked level");
	property p_outrank; vectorValid |-> activeLevel <= $past(activeLevel); endproperty
	a_outrank: assert property (p_outrank) else $error("lower level preempted");
	property p_classblk; vectorValid |-> !$past(classActive); endproperty
	a_classblk: assert property (p_classblk) else $error("accept during class");
	property p_classset; classRaise |=> classActive; endproperty
	a_classset: assert property (p_classset) else $error("class not set");
	property p_classclr; classReset && !classRaise |=> !classActive; endproperty
	a_classclr: assert property (p_classclr) else $error("class not cleared");
	property p_maskwr; levelMaskWr |=> levelMask == $past(levelMaskIn); endproperty
	a_maskwr: assert property (p_maskwr) else $error("level mask not written");
	property p_pswwr; pswWr |=> processorStateWord == $past(pswIn); endproperty
	a_pswwr: assert property (p_pswwr) else $error("state word not written");
	property p_start; startIo && !startBusy |=> chanStrobe && chanKind == $past(startKind) && chanAddr == $past(startDev);
	endproperty
	a_start: assert property (p_start) else $error("start not launched");
endmodule
bind level_irq_unit level_irq_unit_props level_irq_unit_props_i (.*);

//--- sim/priority_level_interrupt_io_unit_bench.sv
// Self-checking bench for the level interrupt unit and a device model.
// Assumes the checker is bound from its own file.
module priority_level_interrupt_io_unit_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = '0, resetn = '0, levelCmd = '0, levelExit = '0, globalEnable = '0, levelMaskWr = '0;
	logic devMaskWr = '0, devMaskEnable = '0, pswWr = '0, memAddrWr = '0, classRaise = '0, classReset = '0;
	logic gprWr = '0, startIo = '0, irqGo = '0;
	logic [1:0] levelCmdValue = '0, devLevelIn = '0, startKind = '0;
	logic [2:0] gprIdx = '0;
	logic [3:0] levelMaskIn = '0;
	logic [4:0] exitStateWord = '0;
	logic [7:0] devMaskAddr = '0, startDev = '0, irqDev = '0, readyDelay = '0;
	logic [15:0] exitInstrPointer = '0, pswIn = '0, memAddrIn = '0, gprWrData = '0, startCount = '0;
	logic [15:0] startData = '0, devData = '0;
	logic startBusy, chanIrqAck, chanStrobe, chanDataOe, chanIrqReq, chanReady, vectorValid, classActive;
	logic [1:0] chanKind, activeLevel;
	logic [3:0] levelMask;
	logic [4:0] levelStateWordOut;
	logic [7:0] chanAddr, chanIrqAddr;
	logic [15:0] gprRdData, dpcReadData, chanDataOut, chanDataIn, currentInstrPointer, vectorAddr;
	logic [15:0] processorStateWord, memoryAddrHolder, levelInstrPointerOut;
	int error_cnt = 0, cmp_count = 0, cycles = 0;
	level_irq_unit level_irq_unit_i (.*);
	io_device_model io_device_model_i (.*);
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end
	//------
	// Tasks
	//------
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cyc(input int n = 1);
		repeat (n) @(negedge clk);
	endtask
	function automatic logic [15:0] vec(input logic [7:0] d);
		return 16'h0100 + {6'h00, d, 2'h0};
	endfunction
	task automatic setDev(input logic [7:0] d, input logic [1:0] l, input logic en);
		devMaskAddr = d;
		devLevelIn = l;
		devMaskEnable = en;
		devMaskWr = 1'b1;
		cyc();
		devMaskWr = 1'b0;
	endtask
	task automatic setMask(input logic [3:0] m);
		levelMaskIn = m;
		levelMaskWr = 1'b1;
		cyc();
		levelMaskWr = 1'b0;
	endtask
	task automatic raise(input logic [7:0] d);
		irqDev = d;
		irqGo = 1'b1;
		cyc();
		irqGo = 1'b0;
	endtask
	task automatic exitLvl();
		levelExit = 1'b1;
		cyc();
		levelExit = 1'b0;
	endtask
	task automatic expectVec(input logic [7:0] d, input logic [1:0] l);
		int n;
		for (n = 0; n < 20 && vectorValid !== 1'b1; n++) cyc();
		chk("vectorValid", 16'h1, {15'h0, vectorValid});
		chk("vectorAddr", vec(d), vectorAddr);
		chk("currentPtr", vec(d), currentInstrPointer);
		chk("activeLevel", {14'h0, l}, {14'h0, activeLevel});
		for (n = 0; n < 10 && chanIrqAck !== 1'b0; n++) cyc();
	endtask
	task automatic expectNone();
		logic s;
		s = 1'b0;
		repeat (12) begin
			cyc();
			s = s | (vectorValid !== 1'b0);
		end
		chk("noAccept", 16'h0, {15'h0, s});
	endtask
	task automatic start();
		int n;
		startIo = 1'b1;
		cyc();
		startIo = 1'b0;
		chk("chanAddr", {8'h00, startDev}, {8'h00, chanAddr});
		if (startKind != 2'h2) chk("dataOut", startData, chanDataOut);
		chk("dataOe", {15'h0, startKind != 2'h2}, {15'h0, chanDataOe});
		for (n = 0; n < 100 && startBusy !== 1'b0; n++) cyc();
	endtask
	//------
	// Main sequence
	//------
	initial begin
		logic [7:0] d;
		logic [1:0] l;
		logic [15:0] w;
		void'($urandom(22));
		cyc(16);
		resetn = 1'b1;
		cyc();
		chk("resetLevel", 16'h3, {14'h0, activeLevel});
		setMask(4'hf);
		w = 16'($urandom);
		pswIn = w;
		memAddrIn = ~w;
		pswWr = 1'b1;
		memAddrWr = 1'b1;
		cyc();
		pswWr = 1'b0;
		memAddrWr = 1'b0;
		chk("memAddr", ~w, memoryAddrHolder);
		chk("stateWord", w, processorStateWord);
		globalEnable = 1'b1;
		for (int i = 0; i < 8; i++) begin
			d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
			l = 2'($urandom);
			setDev(d, l, 1'b1);
			raise(d);
			expectVec(d, l);
			exitLvl();
		end
		chk("exitLevel", 16'h3, {14'h0, activeLevel});
		$display("test vectoring done");
		for (int g = 0; g < 3; g++) begin
			setDev(8'h11, 2'h2, g != 0);
			globalEnable = g != 1;
			setMask(g == 2 ? 4'hb : 4'hf);
			raise(8'h11);
			expectNone();
			setDev(8'h11, 2'h2, 1'b1);
			globalEnable = 1'b1;
			setMask(4'hf);
			expectVec(8'h11, 2'h2);
			exitLvl();
		end
		$display("test gating done");
		exitInstrPointer = 16'h1234;
		exitStateWord = 5'h15;
		gprIdx = 3'h5;
		gprWrData = w;
		gprWr = 1'b1;
		setDev(8'h21, 2'h1, 1'b1);
		gprWr = 1'b0;
		raise(8'h21);
		expectVec(8'h21, 2'h1);
		gprWrData = ~w;
		gprWr = 1'b1;
		setDev(8'h22, 2'h2, 1'b1);
		gprWr = 1'b0;
		raise(8'h22);
		expectNone();
		exitLvl();
		expectVec(8'h22, 2'h2);
		setDev(8'h23, 2'h0, 1'b1);
		raise(8'h23);
		expectVec(8'h23, 2'h0);
		exitLvl();
		chk("resumeLevel", 16'h2, {14'h0, activeLevel});
		exitLvl();
		cyc(2);
		chk("bankReg", w, gprRdData);
		chk("bankPtr", 16'h1234, levelInstrPointerOut);
		chk("bankState", 16'h15, {11'h0, levelStateWordOut});
		levelCmdValue = 2'h1;
		levelCmd = 1'b1;
		cyc();
		levelCmd = 1'b0;
		chk("cmdLevel", 16'h1, {14'h0, activeLevel});
		exitLvl();
		$display("test priority done");
		classRaise = 1'b1;
		cyc();
		classRaise = 1'b0;
		setDev(8'h31, 2'h0, 1'b1);
		raise(8'h31);
		expectNone();
		classReset = 1'b1;
		cyc();
		classReset = 1'b0;
		expectVec(8'h31, 2'h0);
		exitLvl();
		$display("test class done");
		for (int k = 0; k < 2; k++) begin
			startDev = 8'($urandom);
			startKind = 2'(k);
			startData = 16'($urandom);
			devData = 16'($urandom);
			readyDelay = k ? 8'h06 : 8'h00;
			start();
			chk("dpcData", k ? devData : {8'h00, devData[7:0]}, dpcReadData);
		end
		d = 8'($urandom);
		irqDev = d;
		setDev(d, 2'h1, 1'b1);
		startDev = d;
		startKind = 2'h2;
		startCount = 16'h0006;
		readyDelay = 8'h02;
		start();
		expectVec(d, 2'h1);
		exitLvl();
		$display("test transfers done");
		print_verdict();
	end
endmodule

//--- verilog/level_irq_unit.sv
// Priority level interrupt unit with its I/O channel request and transfer side.
// Assumes channel pins are asynchronous; core side runs on clk.
//------------------------------------------------------------
// Summary of operation
// RL1 - Each of four levels has eight 16-bit general registers, an instruction pointer and a state word.
// RL2 - The active level changes on accepting a device interrupt or on a program level-change command.
// RL3 - A preempted level keeps its registers and state word untouched in hardware.
// RL4 - An accepted interrupt vectors to one of 256 entry points chosen by the 8-bit device address.
// RL5 - The requester is identified from the interrupt transaction itself, with no polling.
// RL6 - Software assigns each device to a level and may change it at any time.
// RL7 - Acceptance is gated for all levels, chosen levels, or chosen devices.
// RL8 - A class interrupt may occur on any level and holds that level until the condition is reset.
// RL9 - One shared copy holds current instruction pointer, level mask, processor state word and memory address.
// RL10 - The channel serves up to 256 device addresses through the four levels.
// RL11 - Processor and devices use an asynchronous multidrop channel of address, control and data lines.
// RL12 - One start command in cycle-steal mode runs many transfers, up to 65,535 bytes per control block.
// RL13 - A cycle-steal device always requests an interrupt when its operation ends.
// RL14 - Direct program transfer moves exactly one byte or one word per start; ending interrupt optional.
// RL15 - A request is accepted only when its level outranks the active level, level zero highest; code also accepts level 3 while no level is busy.
//------------------------------------------------------------
`include "level_irq_regs.svh"
module level_irq_unit (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Program control
	input wire logic levelCmd,
	input wire logic [1:0] levelCmdValue,
	input wire logic levelExit,
	input wire logic [`WORD_W-1:0] exitInstrPointer,
	input wire logic [`LSR_W-1:0] exitStateWord,
	input wire logic globalEnable,
	input wire logic [3:0] levelMaskIn,
	input wire logic levelMaskWr,
	input wire logic devMaskWr,
	input wire logic [7:0] devMaskAddr,
	input wire logic devMaskEnable,
	input wire logic [1:0] devLevelIn,
	input wire logic [`WORD_W-1:0] pswIn,
	input wire logic pswWr,
	input wire logic [`WORD_W-1:0] memAddrIn,
	input wire logic memAddrWr,
	// Class interrupts
	input wire logic classRaise,
	input wire logic classReset,
	// General registers
	input wire logic gprWr,
	input wire logic [2:0] gprIdx,
	input wire logic [`WORD_W-1:0] gprWrData,
	output logic [`WORD_W-1:0] gprRdData,
	// Start I/O
	input wire logic startIo,
	input wire logic [7:0] startDev,
	input wire logic [1:0] startKind,
	input wire logic [`WORD_W-1:0] startCount,
	input wire logic [`WORD_W-1:0] startData,
	output logic startBusy,
	output logic [`WORD_W-1:0] dpcReadData,
	// Channel pins
	input wire logic chanIrqReq,
	input wire logic [7:0] chanIrqAddr,
	output logic chanIrqAck,
	output logic chanStrobe,
	output logic [7:0] chanAddr,
	output logic [1:0] chanKind,
	output logic [`WORD_W-1:0] chanDataOut,
	output logic chanDataOe,
	input wire logic [`WORD_W-1:0] chanDataIn,
	input wire logic chanReady,
	// Status
	output logic [1:0] activeLevel,
	output logic [`WORD_W-1:0] currentInstrPointer,
	output logic [`WORD_W-1:0] vectorAddr,
	output logic vectorValid,
	output logic [3:0] levelMask,
	output logic [`WORD_W-1:0] processorStateWord,
	output logic [`WORD_W-1:0] memoryAddrHolder,
	output logic classActive,
	output logic [`WORD_W-1:0] levelInstrPointerOut,
	output logic [`LSR_W-1:0] levelStateWordOut
);
	//------------------------------------------------------------
	// Pin synchronisers
	//------------------------------------------------------------
	logic [1:0] reqSync, rdySync;
	logic [7:0] addrSync0, addrSync1;
	logic [`WORD_W-1:0] dataSync0, dataSync1;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reqSync <= 2'h0;
			rdySync <= 2'h0;
			addrSync0 <= 8'h00;
			addrSync1 <= 8'h00;
			dataSync0 <= 16'h0000;
			dataSync1 <= 16'h0000;
		end else begin
			reqSync <= {reqSync[0], chanIrqReq}; // RL11
			rdySync <= {rdySync[0], chanReady};
			addrSync0 <= chanIrqAddr;
			addrSync1 <= addrSync0;
			dataSync0 <= chanDataIn;
			dataSync1 <= dataSync0;
		end
	end
	wire reqIn = reqSync[1];
	wire rdyIn = rdySync[1];

	//------------------------------------------------------------
	// Device level assignment and gating
	//------------------------------------------------------------
	logic [1:0] devLevel [0:`DEV_COUNT-1];
	logic [`DEV_COUNT-1:0] devEnable;
	genvar gi;
	generate
		for (gi = 0; gi < `DEV_COUNT; gi++) begin : g_dev
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					devLevel[gi] <= 2'h3;
					devEnable[gi] <= 1'b0;
				end else if (devMaskWr && devMaskAddr == 8'(gi)) begin
					devLevel[gi] <= devLevelIn; // RL6
					devEnable[gi] <= devMaskEnable; // RL7
				end
			end
		end
	endgenerate

	// Outranks: lower number wins, level zero highest
	function automatic logic outranks(input logic [1:0] a, input logic [1:0] b, input logic busy);
		outranks = !busy || (a < b);
	endfunction

	//------------------------------------------------------------
	// Level state
	//------------------------------------------------------------
	logic [3:0] levelBusy, next_levelBusy;
	logic [1:0] next_activeLevel;
	logic [`WORD_W-1:0] ipBank [0:`LVL_COUNT-1];
	logic [`LSR_W-1:0] lsrBank [0:`LVL_COUNT-1];
	logic [`LVL_COUNT-1:0] classLvl, next_classLvl;
	logic [3:0] next_levelMask;
	logic [`WORD_W-1:0] next_cip, next_psw, next_sar, next_vector;
	logic next_vectorValid, accept;
	logic [1:0] reqLevel;
	assign reqLevel = devLevel[addrSync1];

	level_irq_pkg::chan_state_t chState, next_chState;

	always_comb begin
		accept = chState == level_irq_pkg::CH_IDLE && reqIn && globalEnable && levelMask[reqLevel]
			&& devEnable[addrSync1] && outranks(reqLevel, activeLevel, |levelBusy)
			&& !classLvl[activeLevel]; // RL5 RL7 RL10 RL15 RL8
		next_activeLevel = activeLevel;
		next_levelBusy = levelBusy;
		next_classLvl = classLvl;
		next_levelMask = levelMaskWr ? levelMaskIn : levelMask; // RL9
		next_psw = pswWr ? pswIn : processorStateWord;
		next_sar = memAddrWr ? memAddrIn : memoryAddrHolder;
		next_cip = currentInstrPointer;
		next_vector = vectorAddr;
		next_vectorValid = 1'b0;
		if (classRaise) begin
			next_classLvl[activeLevel] = 1'b1; // RL8
		end else if (classReset) begin
			next_classLvl[activeLevel] = 1'b0;
		end
		if (accept) begin
			next_activeLevel = reqLevel; // RL2
			next_levelBusy[reqLevel] = 1'b1;
			next_vector = 16'(`VEC_BASE + (16'(addrSync1) << `VEC_SHIFT)); // RL4
			next_cip = next_vector;
			next_vectorValid = 1'b1;
		end else if (levelCmd) begin
			next_activeLevel = levelCmdValue; // RL2
			next_levelBusy[levelCmdValue] = 1'b1;
			next_cip = ipBank[levelCmdValue];
		end else if (levelExit) begin
			next_levelBusy[activeLevel] = 1'b0;
			next_activeLevel = 2'h3;
			for (int i = 3; i >= 0; i--) begin
				if (next_levelBusy[i]) begin
					next_activeLevel = 2'(i);
				end
			end
			next_cip = ipBank[next_activeLevel];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			activeLevel <= 2'h3;
			levelBusy <= 4'h0;
			classLvl <= 4'h0;
			levelMask <= `MASK_RESET;
			processorStateWord <= `PSW_RESET;
			memoryAddrHolder <= `IP_RESET;
			currentInstrPointer <= `IP_RESET;
			vectorAddr <= `IP_RESET;
			vectorValid <= 1'b0;
			for (int i = 0; i < `LVL_COUNT; i++) begin
				ipBank[i] <= `IP_RESET;
				lsrBank[i] <= `LSR_RESET;
			end
		end else begin
			activeLevel <= next_activeLevel;
			levelBusy <= next_levelBusy;
			classLvl <= next_classLvl;
			levelMask <= next_levelMask;
			processorStateWord <= next_psw;
			memoryAddrHolder <= next_sar;
			currentInstrPointer <= next_cip;
			vectorAddr <= next_vector;
			vectorValid <= next_vectorValid;
			if ((accept || levelCmd || levelExit) && next_activeLevel != activeLevel) begin
				ipBank[activeLevel] <= exitInstrPointer; // RL3
				lsrBank[activeLevel] <= exitStateWord; // RL1
			end
		end
	end
	assign classActive = classLvl[activeLevel];
	assign levelInstrPointerOut = ipBank[activeLevel];
	assign levelStateWordOut = lsrBank[activeLevel];

	level_reg_bank u_bank (
		.clk(clk),
		.resetn(resetn),
		.wrEn(gprWr),
		.wrLevel(activeLevel),
		.wrIdx(gprIdx),
		.wrData(gprWrData),
		.rdLevel(activeLevel),
		.rdIdx(gprIdx),
		.rdData(gprRdData)
	);

	//------------------------------------------------------------
	// Channel sequencer
	//------------------------------------------------------------
	logic [16:0] csLeft, next_csLeft;
	logic [7:0] next_chanAddr;
	logic [1:0] next_chanKind;
	logic [`WORD_W-1:0] next_dpcRead, next_chanDataOut;
	logic next_strobe, next_oe;
	always_comb begin
		next_chState = chState;
		next_csLeft = csLeft;
		next_chanAddr = chanAddr;
		next_chanKind = chanKind;
		next_dpcRead = dpcReadData;
		next_chanDataOut = chanDataOut;
		next_strobe = chanStrobe;
		next_oe = chanDataOe;
		unique case (chState)
			level_irq_pkg::CH_IDLE: begin
				if (accept) begin
					next_chState = level_irq_pkg::CH_ACK; // RL5
				end else if (startIo) begin
					next_chanAddr = startDev;
					next_chanKind = startKind;
					next_chanDataOut = startData;
					next_strobe = 1'b1;
					next_oe = startKind != 2'(level_irq_pkg::XFER_CS);
					if (startKind == 2'(level_irq_pkg::XFER_CS)) begin
						next_csLeft = (17'(startCount) > `CS_MAX_BYTES) ? `CS_MAX_BYTES : 17'(startCount); // RL12
						next_chState = level_irq_pkg::CH_CS;
					end else begin
						next_chState = level_irq_pkg::CH_DPC; // RL14
					end
				end
			end
			level_irq_pkg::CH_ACK: begin
				if (!reqIn) begin
					next_chState = level_irq_pkg::CH_IDLE;
				end
			end
			level_irq_pkg::CH_DPC: begin
				if (rdyIn) begin
					next_dpcRead = (chanKind == 2'(level_irq_pkg::XFER_DPC_BYTE))
						? {8'h00, dataSync1[7:0]} : dataSync1; // RL14
					next_strobe = 1'b0;
					next_oe = 1'b0;
					next_chState = level_irq_pkg::CH_DONE;
				end
			end
			level_irq_pkg::CH_CS: begin
				// Each ready moves one word, overlapped with the core
				if (rdyIn) begin
					next_csLeft = (csLeft > 17'h2) ? csLeft - 17'h2 : 17'h0; // RL12
					if (csLeft <= 17'h2) begin
						next_strobe = 1'b0;
						next_chState = level_irq_pkg::CH_DONE; // RL13
					end
				end
			end
			level_irq_pkg::CH_DONE: begin
				if (!rdyIn) begin
					next_chState = level_irq_pkg::CH_IDLE;
				end
			end
		endcase
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			chState <= level_irq_pkg::CH_IDLE;
			csLeft <= 17'h0;
			chanAddr <= 8'h00;
			chanKind <= 2'h0;
			dpcReadData <= 16'h0000;
			chanDataOut <= 16'h0000;
			chanStrobe <= 1'b0;
			chanDataOe <= 1'b0;
		end else begin
			chState <= next_chState;
			csLeft <= next_csLeft;
			chanAddr <= next_chanAddr;
			chanKind <= next_chanKind;
			dpcReadData <= next_dpcRead;
			chanDataOut <= next_chanDataOut;
			chanStrobe <= next_strobe;
			chanDataOe <= next_oe;
		end
	end
	assign chanIrqAck = chState == level_irq_pkg::CH_ACK;
	assign startBusy = chState != level_irq_pkg::CH_IDLE;
endmodule

//--- verilog/level_reg_bank.sv
// Register bank: one general register file per priority level.
// Assumes a single clock; read data come out of a register.
`include "level_irq_regs.svh"
module level_reg_bank (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Write port
	input wire logic wrEn,
	input wire logic [1:0] wrLevel,
	input wire logic [2:0] wrIdx,
	input wire logic [`WORD_W-1:0] wrData,
	// Read port
	input wire logic [1:0] rdLevel,
	input wire logic [2:0] rdIdx,
	output logic [`WORD_W-1:0] rdData
);
	logic [`WORD_W-1:0] mem [0:`LVL_COUNT*`GPR_COUNT-1];
	logic [`WORD_W-1:0] next_rdData;

	always_comb begin
		next_rdData = mem[{rdLevel, rdIdx}];
	end

	// Array kept without reset so it maps onto plain storage
	always_ff @(posedge clk) begin
		if (wrEn) begin
			mem[{wrLevel, wrIdx}] <= wrData; // RL1 RL3
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdData <= `IP_RESET;
		end else begin
			rdData <= next_rdData;
		end
	end
endmodule
